// [rtl/dcd_dma.sv]
`timescale 1ns/10ps
module dcd_dma import dcd_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [15:0] reg_rdata,
    input wire logic [1:0] channel_request_pins,
    input wire logic timer2_out,
    input wire logic [1:0] ser_req,
    input wire logic hold_req,
    output logic hold_ack,
    input wire logic nmi_req,
    input wire logic cpu_lock,
    input wire logic cpu_odd_word,
    input wire logic cpu_bus_need,
    output logic bus_req,
    output dcd_cyc_t bus_cyc,
    input wire logic bus_done,
    input wire logic [15:0] bus_rdata,
    output logic [1:0] tc_irq,
    output logic request_pin0_irq_alias,
    output logic request_pin1_irq_alias
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic logic [19:0] ptr_step(input logic [19:0] p, input logic [1:0] m, input logic w);
        logic [19:0] d;
        d = w ? 20'h00002 : 20'h00001;
        case (m)
            STEP_INC: ptr_step = p + d;
            STEP_DEC: ptr_step = p - d;
            default: ptr_step = p;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [19:0] src_q [2];
    logic [19:0] dst_q [2];
    logic [15:0] cnt_q [2];
    dcd_ctrl_t ctrl_q [2];
    logic [1:0] sw_q;
    dcd_state_t st_q;
    logic cur_q;
    logic last_q;
    logic [2:0] ph_q;
    logic [2:0] gap_q;
    logic [1:0] drq_s;
    logic hold_s;
    logic nmi_s;
    logic [1:0] ready;
    logic [1:0] start_ch;
    logic blocked;
    logic pick;
    logic rd_done;
    logic wr_done;
    logic [1:0] done_ch;
    logic [1:0] alias_q;
    logic [15:0] cnt_dec [2];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for request pins, hold and NMI.

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= {nmi_req, hold_req, channel_request_pins};
            sync2_q <= sync1_q;
        end
    end

    assign drq_s = sync2_q[1:0];
    assign hold_s = sync2_q[2];
    assign nmi_s = sync2_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // Request selection and arbitration.

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            logic r;
            r = 1'b0;
            case (ctrl_q[i].req_sel)
                REQ_PIN: r = drq_s[i] && !ctrl_q[i].pin_irq;
                REQ_TIMER2: r = timer2_out;
                REQ_SERIAL: r = ser_req[i];
                default: r = sw_q[i];
            endcase
            ready[i] = ctrl_q[i].enable && ((ctrl_q[i].sync == SYNC_NONE) || r);
        end
    end

    // Hold, NMI, a locked sequence or an odd word split keeps new transfers out.
    assign blocked = hold_s || nmi_s || cpu_lock || cpu_odd_word;

    always_comb begin
        if (ready == 2'b11) begin
            if (ctrl_q[0].prio != ctrl_q[1].prio) begin
                pick = ctrl_q[1].prio;
            end else begin
                pick = ~last_q;
            end
        end else begin
            pick = ready[1];
        end
    end

    assign rd_done = (st_q == ST_RD) && bus_done && (ph_q >= CYC_MIN - 3'h1);
    assign wr_done = (st_q == ST_WR) && bus_done && (ph_q >= CYC_MIN - 3'h1);
    assign start_ch = ((st_q == ST_IDLE) && !blocked && (ready != 2'b00)) ? (pick ? 2'b10 : 2'b01) : 2'b00;
    assign done_ch = wr_done ? (cur_q ? 2'b10 : 2'b01) : 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer: read cycle, write cycle, optional gap.

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cur_q <= 1'b0;
            last_q <= 1'b0;
            ph_q <= 3'h0;
            gap_q <= 3'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    ph_q <= 3'h0;
                    if (start_ch != 2'b00) begin
                        cur_q <= pick;
                        last_q <= pick;
                        st_q <= ST_RD;
                    end
                end
                ST_RD: begin
                    ph_q <= (ph_q < CYC_MIN) ? ph_q + 3'h1 : ph_q;
                    if (rd_done) begin
                        ph_q <= 3'h0;
                        st_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    ph_q <= (ph_q < CYC_MIN) ? ph_q + 3'h1 : ph_q;
                    if (wr_done) begin
                        if (ctrl_q[cur_q].sync == SYNC_DST) begin
                            gap_q <= cpu_bus_need ? GAP_DST_CPU : GAP_DST_FREE;
                            st_q <= ST_GAP;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_GAP: begin
                    gap_q <= gap_q - 3'h1;
                    if (gap_q <= 3'h1) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle presented to the system bus.

    assign bus_req = (st_q == ST_RD) || (st_q == ST_WR);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_cyc <= '0;
        end else if (start_ch != 2'b00) begin
            bus_cyc.addr <= src_q[pick];
            bus_cyc.io <= !ctrl_q[pick].src_mem;
            bus_cyc.wr <= 1'b0;
            bus_cyc.word <= ctrl_q[pick].word;
            bus_cyc.data <= 16'h0000;
        end else if (rd_done) begin
            bus_cyc.addr <= dst_q[cur_q];
            bus_cyc.io <= !ctrl_q[cur_q].dst_mem;
            bus_cyc.wr <= 1'b1;
            bus_cyc.data <= bus_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel registers; a software write wins over a hardware update.

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cnt_dec[i] = cnt_q[i] - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                src_q[i] <= PTR_RST;
                dst_q[i] <= PTR_RST;
                cnt_q[i] <= COUNT_RST;
                ctrl_q[i] <= CTRL_RST;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (done_ch[i]) begin
                    src_q[i] <= ptr_step(src_q[i], ctrl_q[i].src_step, ctrl_q[i].word);
                    dst_q[i] <= ptr_step(dst_q[i], ctrl_q[i].dst_step, ctrl_q[i].word);
                    cnt_q[i] <= cnt_dec[i];
                    if (ctrl_q[i].term_en && (cnt_dec[i] == 16'h0000)) begin
                        ctrl_q[i].enable <= 1'b0;
                    end
                end
                if (reg_we && (reg_addr[3] == i[0])) begin
                    case (reg_addr[2:0])
                        REG_SRC_LO: src_q[i][15:0] <= reg_wdata;
                        REG_SRC_HI: src_q[i][19:16] <= reg_wdata[3:0];
                        REG_DST_LO: dst_q[i][15:0] <= reg_wdata;
                        REG_DST_HI: dst_q[i][19:16] <= reg_wdata[3:0];
                        REG_COUNT: cnt_q[i] <= reg_wdata;
                        REG_CTRL: ctrl_q[i] <= reg_wdata;
                        default: ;
                    endcase
                end
            end
        end
    end

    // Software request: set by a status write, taken when the channel starts.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (reg_we && (reg_addr[3] == i[0]) && (reg_addr[2:0] == REG_STAT) && reg_wdata[0]) begin
                    sw_q[i] <= 1'b1;
                end else if (start_ch[i] && (ctrl_q[i].req_sel == REQ_SOFT)) begin
                    sw_q[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port.

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_re) begin
            case (reg_addr[2:0])
                REG_SRC_LO: reg_rdata <= src_q[reg_addr[3]][15:0];
                REG_SRC_HI: reg_rdata <= {12'h000, src_q[reg_addr[3]][19:16]};
                REG_DST_LO: reg_rdata <= dst_q[reg_addr[3]][15:0];
                REG_DST_HI: reg_rdata <= {12'h000, dst_q[reg_addr[3]][19:16]};
                REG_COUNT: reg_rdata <= cnt_q[reg_addr[3]];
                REG_CTRL: reg_rdata <= ctrl_q[reg_addr[3]];
                REG_STAT: reg_rdata <= {14'h0000, bus_req && (cur_q == reg_addr[3]), sw_q[reg_addr[3]]};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hold grant, terminal count interrupt and pin interrupt aliases.

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_ack <= 1'b0;
        end else begin
            hold_ack <= hold_s && (st_q == ST_IDLE);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tc_irq <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                tc_irq[i] <= done_ch[i] && ctrl_q[i].irq_en && (cnt_dec[i] == 16'h0000);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            alias_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                alias_q[i] <= drq_s[i] && (!ctrl_q[i].enable || ctrl_q[i].pin_irq ||
                    (ctrl_q[i].req_sel != REQ_PIN) || (ctrl_q[i].sync == SYNC_NONE));
            end
        end
    end

    assign request_pin0_irq_alias = alias_q[0];
    assign request_pin1_irq_alias = alias_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [4:0] xfer_len_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            xfer_len_q <= 5'h00;
        end else if (st_q == ST_IDLE) begin
            xfer_len_q <= 5'h00;
        end else if (xfer_len_q != 5'h1f) begin
            xfer_len_q <= xfer_len_q + 5'h01;
        end
    end

    property p_min_clocks;
        @(posedge clk_sys) disable iff (rst) wr_done |-> xfer_len_q >= 5'h07;
    endproperty
    a_min_clocks: assert property (p_min_clocks) else $error("Transfer shorter than eight clocks.");

    property p_rd_then_wr;
        @(posedge clk_sys) disable iff (rst) rd_done |=> (st_q == ST_WR) && bus_cyc.wr;
    endproperty
    a_rd_then_wr: assert property (p_rd_then_wr) else $error("Read not followed by write.");

    property p_hold_first;
        @(posedge clk_sys) disable iff (rst) hold_s && (st_q == ST_IDLE) |=> (st_q == ST_IDLE) && hold_ack;
    endproperty
    a_hold_first: assert property (p_hold_first) else $error("DMA started ahead of bus hold.");

    property p_nmi_halt;
        @(posedge clk_sys) disable iff (rst) nmi_s && (st_q == ST_IDLE) |=> st_q == ST_IDLE;
    endproperty
    a_nmi_halt: assert property (p_nmi_halt) else $error("DMA started during NMI.");

    property p_cpu_lock;
        @(posedge clk_sys) disable iff (rst) (cpu_lock || cpu_odd_word) && (st_q == ST_IDLE) |=> !bus_req;
    endproperty
    a_cpu_lock: assert property (p_cpu_lock) else $error("DMA broke a locked CPU sequence.");

    property p_word_step;
        @(posedge clk_sys) disable iff (rst)
            done_ch[0] && ctrl_q[0].word && (ctrl_q[0].src_step == STEP_INC) && !reg_we
            |=> src_q[0] == $past(src_q[0]) + 20'h00002;
    endproperty
    a_word_step: assert property (p_word_step) else $error("Word pointer did not step by two.");

    property p_term_stop;
        @(posedge clk_sys) disable iff (rst)
            done_ch[1] && ctrl_q[1].term_en && (cnt_q[1] == 16'h0001) && !reg_we |=> !ctrl_q[1].enable;
    endproperty
    a_term_stop: assert property (p_term_stop) else $error("Channel did not stop at count end.");

    property p_tc_irq;
        @(posedge clk_sys) disable iff (rst) tc_irq[0] |-> $past(ctrl_q[0].irq_en) && (cnt_q[0] == 16'h0000);
    endproperty
    a_tc_irq: assert property (p_tc_irq) else $error("Spurious terminal count interrupt.");

    property p_dst_gap;
        @(posedge clk_sys) disable iff (rst)
            wr_done && (ctrl_q[cur_q].sync == SYNC_DST) && !cpu_bus_need |=> (st_q == ST_GAP)[*2] ##1 st_q == ST_IDLE;
    endproperty
    a_dst_gap: assert property (p_dst_gap) else $error("Destination sync gap wrong.");

    property p_alias;
        @(posedge clk_sys) disable iff (rst)
            !ctrl_q[0].enable && !$past(ctrl_q[0].enable) |-> request_pin0_irq_alias == $past(drq_s[0]);
    endproperty
    a_alias: assert property (p_alias) else $error("Request pin not passed as interrupt.");

endmodule

// [rtl/dcd_pkg.sv]
package dcd_pkg;

    localparam logic [2:0] REG_SRC_LO = 3'h0;
    localparam logic [2:0] REG_SRC_HI = 3'h1;
    localparam logic [2:0] REG_DST_LO = 3'h2;
    localparam logic [2:0] REG_DST_HI = 3'h3;
    localparam logic [2:0] REG_COUNT = 3'h4;
    localparam logic [2:0] REG_CTRL = 3'h5;
    localparam logic [2:0] REG_STAT = 3'h6;

    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [19:0] PTR_RST = 20'h00000;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_INC = 2'h1;
    localparam logic [1:0] STEP_DEC = 2'h2;

    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_SRC = 2'h1;
    localparam logic [1:0] SYNC_DST = 2'h2;

    localparam logic [1:0] REQ_PIN = 2'h0;
    localparam logic [1:0] REQ_TIMER2 = 2'h1;
    localparam logic [1:0] REQ_SERIAL = 2'h2;
    localparam logic [1:0] REQ_SOFT = 2'h3;

    localparam logic [2:0] CYC_MIN = 3'h4;
    localparam logic [2:0] GAP_DST_FREE = 3'h2;
    localparam logic [2:0] GAP_DST_CPU = 3'h4;

    typedef struct packed {
        logic dst_mem;
        logic [1:0] dst_step;
        logic src_mem;
        logic [1:0] src_step;
        logic term_en;
        logic irq_en;
        logic [1:0] sync;
        logic prio;
        logic pin_irq;
        logic [1:0] req_sel;
        logic enable;
        logic word;
    } dcd_ctrl_t;

    typedef struct packed {
        logic [19:0] addr;
        logic io;
        logic wr;
        logic word;
        logic [15:0] data;
    } dcd_cyc_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD = 2'b01,
        ST_WR = 2'b11,
        ST_GAP = 2'b10
    } dcd_state_t;

endpackage

// [sim/dcd_mem_model.sv]
`timescale 1ns/10ps
module dcd_mem_model import dcd_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_req,
    input wire dcd_cyc_t bus_cyc,
    input wire logic [3:0] lat,
    output logic bus_done,
    output logic [15:0] bus_rdata
);
    dcd_cyc_t seen_q[$];
    int busy_n;
    logic req_q;
    logic wr_q;
    logic [3:0] cnt_q;
    logic [15:0] last_q;
    logic start;
    logic [15:0] pat;

    // A phase starts when the request rises or the direction turns.
    assign start = bus_req && (!req_q || bus_cyc.wr !== wr_q);
    // Memory and I/O are sixteen bits wide, so word moves are always legal here.
    assign pat = bus_cyc.word ? bus_cyc.addr[15:0] ^ 16'h3c5a : {2{bus_cyc.addr[7:0] ^ 8'h5a}};
    assign bus_done = bus_req && !start && cnt_q >= lat;
    // Outside a finishing read the data lines show the inverse of the last value.
    assign bus_rdata = (bus_done && !bus_cyc.wr) ? pat : ~last_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 4'h0;
            last_q <= 16'h0000;
            busy_n <= 0;
        end else begin
            req_q <= bus_req;
            wr_q <= bus_cyc.wr;
            last_q <= bus_rdata;
            cnt_q <= !bus_req ? 4'h0 : start ? 4'h1 : (cnt_q == 4'hf ? cnt_q : cnt_q + 4'h1);
            if (bus_req) begin
                busy_n <= busy_n + 1;
            end
            if (start) begin
                seen_q.push_back(bus_cyc);
            end
        end
    end
endmodule

// [sim/tb_dual_channel_dma_controller.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_dual_channel_dma_controller import dcd_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] channel_request_pins = 2'h0;
    logic timer2_out = 1'b0;
    logic [1:0] ser_req = 2'h0;
    logic hold_req = 1'b0;
    logic hold_ack;
    logic nmi_req = 1'b0;
    logic cpu_lock = 1'b0;
    logic cpu_odd_word = 1'b0;
    logic cpu_bus_need = 1'b0;
    logic bus_req;
    dcd_cyc_t bus_cyc;
    logic bus_done;
    logic [15:0] bus_rdata;
    logic [1:0] tc_irq;
    logic [1:0] pin_alias;
    logic [3:0] lat = 4'h3;
    int n_fail = 0;
    int n_compared = 0;
    int n_tc0 = 0;
    int n_tc1 = 0;
    int busy0 = 0;
    integer seed = 32'h466e;
    dcd_cyc_t exp_q[$];
    dcd_ctrl_t c;
    logic [15:0] v;
    logic [15:0] r;

    dcd_dma DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .channel_request_pins(channel_request_pins),
        .timer2_out(timer2_out), .ser_req(ser_req), .hold_req(hold_req), .hold_ack(hold_ack),
        .nmi_req(nmi_req), .cpu_lock(cpu_lock), .cpu_odd_word(cpu_odd_word), .cpu_bus_need(cpu_bus_need),
        .bus_req(bus_req), .bus_cyc(bus_cyc), .bus_done(bus_done), .bus_rdata(bus_rdata), .tc_irq(tc_irq),
        .request_pin0_irq_alias(pin_alias[0]), .request_pin1_irq_alias(pin_alias[1]));
    dcd_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_cyc(bus_cyc), .lat(lat),
        .bus_done(bus_done), .bus_rdata(bus_rdata));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (tc_irq[0] === 1'b1) n_tc0++;
        if (tc_irq[1] === 1'b1) n_tc1++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] pat(input logic [19:0] a, input logic w);
        return w ? a[15:0] ^ 16'h3c5a : {2{a[7:0] ^ 8'h5a}};
    endfunction

    function automatic logic [19:0] nxt(input logic [19:0] p, input logic [1:0] m, input logic [19:0] st);
        return m == STEP_INC ? p + st : (m == STEP_DEC ? p - st : p);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic prog(input logic ch, input logic [19:0] s, input logic [19:0] d, input int n, input dcd_ctrl_t k);
        logic [19:0] st;
        st = k.word ? 20'h00002 : 20'h00001;
        reg_wr({ch, REG_SRC_LO}, s[15:0]);
        reg_wr({ch, REG_SRC_HI}, {12'h000, s[19:16]});
        reg_wr({ch, REG_DST_LO}, d[15:0]);
        reg_wr({ch, REG_DST_HI}, {12'h000, d[19:16]});
        reg_wr({ch, REG_COUNT}, n[15:0]);
        reg_wr({ch, REG_CTRL}, k);
        repeat (n) begin
            exp_q.push_back({s, !k.src_mem, 1'b0, k.word, 16'h0000});
            exp_q.push_back({d, !k.dst_mem, 1'b1, k.word, pat(s, k.word)});
            s = nxt(s, k.src_step, st);
            d = nxt(d, k.dst_step, st);
        end
    endtask

    task automatic check_run(input string tn, input logic alt);
        int i;
        dcd_cyc_t ex;
        dcd_cyc_t gt;
        for (i = 0; i < 3000 && u_mem.seen_q.size() < exp_q.size(); i++) @(posedge clk_sys);
        if (i == 3000) begin
            n_fail++;
            report_and_stop();
        end
        cyc(30);
        `CHK("cycle count", exp_q.size(), u_mem.seen_q.size())
        `CHK("min clocks", 1'b1, u_mem.busy_n - busy0 >= 4 * exp_q.size())
        if (alt) begin
            for (i = 0; i + 2 < exp_q.size(); i += 2)
                `CHK("alternation", 1'b1, u_mem.seen_q[i].addr[19:16] !== u_mem.seen_q[i+2].addr[19:16])
        end
        while (!alt && exp_q.size() > 0 && u_mem.seen_q.size() > 0) begin
            ex = exp_q.pop_front();
            gt = u_mem.seen_q.pop_front();
            `CHK("bus cycle", ex[38:16], gt[38:16])
            if (ex.wr)
                `CHK("write data", ex.data, gt.data)
        end
        exp_q.delete();
        u_mem.seen_q.delete();
        busy0 = u_mem.busy_n;
        $display("test %s done", tn);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int k;
        cyc(2);
        rst <= 1'b0;
        for (i = 0; i < 12; i++) begin
            v = 16'($random(seed));
            k = i % 6;
            if (k == 1 || k == 3) v = v & 16'h000f;
            if (k == 5) v[1] = 1'b0;
            reg_rd({i >= 6, k[2:0]}, r);
            `CHK("reset value", 16'h0000, r)
            reg_wr({i >= 6, k[2:0]}, v);
            reg_rd({i >= 6, k[2:0]}, r);
            `CHK("register", v, r)
        end
        reg_wr(4'h7, 16'hffff);
        reg_rd(4'h7, r);
        `CHK("unmapped", 16'h0000, r)
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            c = '0;
            {c.enable, c.term_en, c.irq_en, c.word, c.src_mem, c.src_step} = {5'h1f, STEP_INC};
            c.sync = i[0] ? SYNC_DST : SYNC_SRC;
            c.req_sel = i[1:0];
            cpu_bus_need <= i[1];
            lat <= 4'h1 + 4'($unsigned($random(seed)) % 5);
            prog(1'b0, 20'($random(seed)), 20'($random(seed)), 1, c);
            cyc(20);
            `CHK("waits for request", 0, u_mem.seen_q.size())
            case (i)
                0: channel_request_pins <= 2'h1;
                1: timer2_out <= 1'b1;
                2: ser_req <= 2'h1;
                default: reg_wr({1'b0, REG_STAT}, 16'h0001);
            endcase
            check_run("request source", 1'b0);
            `CHK("terminal pulses", i + 1, n_tc0)
            reg_rd({1'b0, REG_CTRL}, r);
            `CHK("auto stop", {c[15:2], 1'b0, c[0]}, r)
            if (i == 0) `CHK("pin as interrupt", 1'b1, pin_alias[0])
            {channel_request_pins, timer2_out, ser_req} <= 5'h00;
        end
        c = '0;
        {c.enable, c.term_en, c.dst_mem, c.src_step, c.dst_step} = {3'h7, STEP_DEC, STEP_HOLD};
        lat <= 4'h0;
        prog(1'b1, 20'h0a1b3, 20'h00101, 3, c);
        check_run("byte decrement", 1'b0);
        c = '0;
        {c.enable, c.sync, c.pin_irq} = {1'b1, SYNC_SRC, 1'b1};
        prog(1'b1, 20'h00000, 20'h00000, 0, c);
        channel_request_pins <= 2'h2;
        cyc(20);
        `CHK("pin repurposed", 0, u_mem.seen_q.size())
        `CHK("pin alias", 1'b1, pin_alias[1])
        channel_request_pins <= 2'h0;
        reg_wr({1'b1, REG_CTRL}, 16'h0000);
        $display("test pin interrupt done");
        for (i = 0; i < 4; i++) begin
            lat <= 4'h2;
            {cpu_odd_word, cpu_lock, nmi_req, hold_req} <= 4'h1 << i;
            cyc(6);
            if (i == 0) `CHK("hold grant", 1'b1, hold_ack)
            c = '0;
            {c.enable, c.term_en, c.word, c.src_mem, c.dst_mem, c.src_step} = {5'h1f, STEP_INC};
            prog(1'b0, 20'h00010, 20'h00020, 2, c);
            cyc(20);
            `CHK("blocked", 0, u_mem.seen_q.size())
            {cpu_odd_word, cpu_lock, nmi_req, hold_req} <= 4'h0;
            check_run("blocker", 1'b0);
        end
        for (i = 0; i < 2; i++) begin
            hold_req <= 1'b1;
            cyc(4);
            c = '0;
            {c.enable, c.term_en, c.irq_en, c.word, c.src_mem, c.dst_mem} = 6'h3f;
            {c.src_step, c.dst_step, c.prio} = {STEP_INC, STEP_INC, i == 0};
            prog(1'b1, 20'h20000, 20'h30000, 2, c);
            c.prio = 1'b0;
            prog(1'b0, 20'h10000, 20'h40000, 2, c);
            hold_req <= 1'b0;
            check_run("arbitration", i == 1);
        end
        `CHK("terminal pulses ch0", 6, n_tc0)
        `CHK("terminal pulses ch1", 2, n_tc1)
        report_and_stop();
    end
endmodule
